// ### clock_buffer_output_control.sv
// control logic of a ten-pair zero-delay clock buffer: serial write slave,
// output enables, low-frequency shutdown, test bypass and lock wait.
// assumes the analog pll and pads sit outside; pads AND pair_oe_o with
// !low_power_o because the ref-domain enables freeze when ref stops.
`timescale 1ns/1ps
module clock_buffer_output_control
   import clkbuf_pkg::*;
#(
   parameter int DET_FREQ_MHZ = DET_FREQ_DEF_MHZ
) (
   input  wire logic                 clock_i,
   input  wire logic                 arst_n_i,
   input  wire logic                 ref_clk_i,
   input  wire logic                 scl_i,
   input  wire logic                 serial_data_line_i,
   input  wire logic                 analog_supply_pin_i,
   output logic                      serial_data_line_o,
   output logic                      serial_data_line_oe_o,
   output logic      [NUM_PAIRS-1:0] pair_oe_o,
   output logic                      fb_oe_o,
   output logic                      pll_run_o,
   output logic                      bypass_o,
   output logic                      low_power_o,
   output logic                      lock_wait_o
);
   // loaded on the pll start edge: lock wait then stands for LOCK_CYC cycles
   localparam logic [8:0] LOCK_LOAD  = 9'(LOCK_CYC);
   localparam int         LOCK_BOUND = 401;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [2:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       avdd_s;
   logic       low_freq;

   // idle bus and a live supply are the safe reset assumption
   sync2 #(.W(3), .RST_VAL(3'h7)) u_pin_sync (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .d_i      ({scl_i, serial_data_line_i, analog_supply_pin_i}),
      .q_o      (pins_s)
   );

   assign scl_s  = pins_s[2];
   assign sda_s  = pins_s[1];
   assign avdd_s = pins_s[0];

   freq_detect #(.DET_FREQ_MHZ(DET_FREQ_MHZ)) u_freq_detect (
      .clock_i    (clock_i),
      .arst_n_i   (arst_n_i),
      .ref_clk_i  (ref_clk_i),
      .low_freq_o (low_freq)
   );

   ////////////////////////////////////////////////////////////////////////
   // serial write slave

   serial_state_t state_r;
   serial_state_t state_nxt;
   logic [3:0]    bit_cnt_r;
   logic [3:0]    bit_cnt_nxt;
   logic [2:0]    byte_cnt_r;
   logic [2:0]    byte_cnt_nxt;
   logic [7:0]    shift_r;
   logic [7:0]    shift_nxt;
   logic          ack_ok_r;
   logic          ack_ok_nxt;
   logic          sda_oe_r;
   logic          sda_oe_nxt;
   logic          scl_q_r;
   logic          sda_q_r;
   logic          scl_rise;
   logic          scl_fall;
   logic          start_cond;
   logic          stop_cond;
   logic [7:0]    byte_in;
   reg_write_t    wr;

   assign scl_rise   = scl_s & ~scl_q_r;
   assign scl_fall   = ~scl_s & scl_q_r;
   assign start_cond = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop_cond  = scl_s & scl_q_r & ~sda_q_r & sda_s;
   assign byte_in    = {shift_r[6:0], sda_s};

   always_comb begin
      state_nxt    = state_r;
      bit_cnt_nxt  = bit_cnt_r;
      byte_cnt_nxt = byte_cnt_r;
      shift_nxt    = shift_r;
      ack_ok_nxt   = ack_ok_r;
      sda_oe_nxt   = sda_oe_r;
      wr           = '0;
      if (start_cond) begin
         state_nxt    = ST_BITS;
         bit_cnt_nxt  = '0;
         byte_cnt_nxt = BYTE_ADDR;
         sda_oe_nxt   = 1'b0;
      end else if (stop_cond) begin
         state_nxt  = ST_IDLE;
         sda_oe_nxt = 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
            end
            ST_BITS: begin
               if (scl_rise && bit_cnt_r != BITS_PER_BYTE) begin
                  shift_nxt   = byte_in;
                  bit_cnt_nxt = bit_cnt_r + 1'b1;
                  if (bit_cnt_r == BIT_LAST) begin
                     // only a write to our address is answered; reads refused
                     if (byte_cnt_r == BYTE_ADDR) begin
                        ack_ok_nxt = (byte_in == DEV_ADDR_WR);
                     end else begin
                        ack_ok_nxt = 1'b1;
                     end
                     wr.data  = byte_in;
                     wr.idx   = (byte_cnt_r == BYTE_DATA1);
                     // dummy bytes and anything past byte1 are dropped
                     wr.valid = (byte_cnt_r == BYTE_DATA0) ||
                                (byte_cnt_r == BYTE_DATA1);
                  end
               end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
                  if (ack_ok_r) begin
                     state_nxt  = ST_ACK;
                     sda_oe_nxt = 1'b1;
                  end else begin
                     state_nxt = ST_IGNORE;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state_nxt   = ST_BITS;
                  sda_oe_nxt  = 1'b0;
                  bit_cnt_nxt = '0;
                  if (byte_cnt_r != BYTE_LAST) begin
                     byte_cnt_nxt = byte_cnt_r + 1'b1;
                  end
               end
            end
            ST_IGNORE: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r    <= ST_IDLE;
         bit_cnt_r  <= '0;
         byte_cnt_r <= BYTE_ADDR;
         shift_r    <= '0;
         ack_ok_r   <= 1'b0;
         sda_oe_r   <= 1'b0;
         scl_q_r    <= 1'b1;
         sda_q_r    <= 1'b1;
      end else begin
         state_r    <= state_nxt;
         bit_cnt_r  <= bit_cnt_nxt;
         byte_cnt_r <= byte_cnt_nxt;
         shift_r    <= shift_nxt;
         ack_ok_r   <= ack_ok_nxt;
         sda_oe_r   <= sda_oe_nxt;
         scl_q_r    <= scl_s;
         sda_q_r    <= sda_s;
      end
   end

   // open drain: the line is only ever pulled low
   assign serial_data_line_o    = 1'b0;
   assign serial_data_line_oe_o = sda_oe_r;

   ////////////////////////////////////////////////////////////////////////
   // enable registers

   logic [NUM_PAIRS-1:0] en_r;
   logic [NUM_PAIRS-1:0] en_nxt;

   always_comb begin
      en_nxt = en_r;
      if (wr.valid && !wr.idx) begin
         for (int i = 0; i < 8; i++) begin
            en_nxt[i] = wr.data[7-i];
         end
      end else if (wr.valid && wr.idx) begin
         en_nxt[8] = wr.data[7];
         en_nxt[9] = wr.data[6]; // reserved low bits are not stored
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         en_r <= EN_RESET;
      end else begin
         en_r <= en_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pll mode and lock wait

   pll_mode_t  mode_r;
   pll_mode_t  mode_nxt;
   logic [8:0] lock_cnt_r;
   logic [8:0] lock_cnt_nxt;
   logic       lock_wait_r;
   logic       lock_wait_nxt;

   always_comb begin
      mode_nxt.bypass    = ~avdd_s;
      mode_nxt.low_power = low_freq & avdd_s;
      // running pll keeps true/complement aligned with the input
      mode_nxt.pll_run   = avdd_s & ~low_freq;
      lock_cnt_nxt       = lock_cnt_r;
      if (mode_nxt.pll_run && !mode_r.pll_run) begin
         lock_cnt_nxt = LOCK_LOAD;
      end else if (lock_cnt_r != '0) begin
         lock_cnt_nxt = lock_cnt_r - 1'b1;
      end
      lock_wait_nxt = ~mode_nxt.pll_run | (lock_cnt_nxt != '0);
   end

   // reset value makes power-up behave like a fresh pll start
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_r      <= '{bypass: 1'b0, low_power: 1'b1, pll_run: 1'b0};
         lock_cnt_r  <= '0;
         lock_wait_r <= 1'b1;
      end else begin
         mode_r      <= mode_nxt;
         lock_cnt_r  <= lock_cnt_nxt;
         lock_wait_r <= lock_wait_nxt;
      end
   end

   assign bypass_o    = mode_r.bypass;
   assign low_power_o = mode_r.low_power;
   assign pll_run_o   = mode_r.pll_run;
   assign lock_wait_o = lock_wait_r;

   ////////////////////////////////////////////////////////////////////////
   // reference clock domain: enables applied in the low phase

   logic [NUM_PAIRS:0]   ref_s;
   logic [NUM_PAIRS-1:0] en_ref;
   logic                 outs_on_ref;
   logic [NUM_PAIRS-1:0] pair_oe_r;
   logic [NUM_PAIRS-1:0] pair_oe_nxt;
   logic                 fb_oe_r;
   logic                 fb_oe_nxt;

   sync2 #(.W(NUM_PAIRS + 1), .RST_VAL({EN_RESET, 1'b0})) u_ref_sync (
      .clock_i  (ref_clk_i),
      .arst_n_i (arst_n_i),
      .d_i      ({en_r, ~mode_r.low_power}),
      .q_o      (ref_s)
   );

   assign en_ref      = ref_s[NUM_PAIRS:1];
   assign outs_on_ref = ref_s[0];

   always_comb begin
      pair_oe_nxt = en_ref & {NUM_PAIRS{outs_on_ref}};
      fb_oe_nxt   = outs_on_ref;
   end

   // falling edge: an enable never cuts a high pulse short
   always_ff @(negedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pair_oe_r <= '0;
         fb_oe_r   <= 1'b0;
      end else begin
         pair_oe_r <= pair_oe_nxt;
         fb_oe_r   <= fb_oe_nxt;
      end
   end

   assign pair_oe_o = pair_oe_r;
   assign fb_oe_o   = fb_oe_r;

   ////////////////////////////////////////////////////////////////////////
   // checks

   addr_match_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (state_r == ST_BITS && scl_rise && bit_cnt_r == BIT_LAST &&
       byte_cnt_r == BYTE_ADDR) |=> (ack_ok_r == ($past(byte_in) == DEV_ADDR_WR)))
      else $error("address acknowledge decision wrong");

   ack_only_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      sda_oe_r |-> (state_r == ST_ACK && ack_ok_r))
      else $error("data line driven outside an acknowledge");

   ack_give_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (state_r == ST_BITS && scl_fall && bit_cnt_r == BITS_PER_BYTE && ack_ok_r &&
       !start_cond && !stop_cond) |=> sda_oe_r)
      else $error("accepted byte not acknowledged");

   no_extra_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (byte_cnt_r == BYTE_LAST || byte_cnt_r < BYTE_DATA0) |-> !wr.valid)
      else $error("non data byte written to enables");

   byte0_map_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (wr.valid && !wr.idx) |=> (en_r[0] == $past(wr.data[7]) &&
       en_r[7] == $past(wr.data[0]) && $stable(en_r[9:8])))
      else $error("first data byte mapped wrong");

   byte1_map_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (wr.valid && wr.idx) |=> (en_r[8] == $past(wr.data[7]) &&
       en_r[9] == $past(wr.data[6]) && $stable(en_r[7:0])))
      else $error("second data byte mapped wrong");

   en_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !wr.valid |=> $stable(en_r))
      else $error("enable changed without a write");

   lock_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      $rose(mode_r.pll_run) |-> lock_wait_r [*8])
      else $error("lock wait too short");

   lock_end_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ($rose(mode_r.pll_run) ##1 mode_r.pll_run [*8]) |->
      ##[1:LOCK_BOUND] (!lock_wait_r || !mode_r.pll_run))
      else $error("lock wait never ends");

   bypass_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      bypass_o |-> (!pll_run_o && !low_power_o))
      else $error("bypass with pll running or powered down");

   low_power_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (low_freq && avdd_s) |=> (low_power_o && !pll_run_o))
      else $error("slow input did not shut down");

   fb_keep_a: assert property (@(negedge ref_clk_i) disable iff (!arst_n_i)
      outs_on_ref |=> fb_oe_r)
      else $error("feedback pair disabled while outputs on");

   low_phase_a: assert property (@(negedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> (pair_oe_r == $past(en_ref & {NUM_PAIRS{outs_on_ref}})))
      else $error("pair enable not applied at low phase");
endmodule

// ### clkbuf_pkg.sv
// constants and types shared by the clock buffer control files
// assumes a 40 MHz system clock; the reference clock is a separate domain
package clkbuf_pkg;
   localparam int          CLK_MHZ          = 40;
   localparam int          SERIAL_KBPS      = 100;
   localparam int          NUM_PAIRS        = 10;
   localparam logic [7:0]  DEV_ADDR_WR      = 8'hD2;
   localparam logic [3:0]  BIT_LAST         = 4'h7;
   localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
   localparam logic [2:0]  BYTE_ADDR        = 3'h0;
   localparam logic [2:0]  BYTE_DATA0       = 3'h3;
   localparam logic [2:0]  BYTE_DATA1       = 3'h4;
   localparam logic [2:0]  BYTE_LAST        = 3'h5;
   localparam logic [9:0]  EN_RESET         = 10'h3FF;
   localparam int          DIV_BITS         = 4;
   localparam int          DET_FREQ_DEF_MHZ = 10;
   localparam int          DET_WINDOW_NS    = 4000;
   localparam int          DET_WINDOW_CYC   = DET_WINDOW_NS * CLK_MHZ / 1000;
   localparam int          LOCK_TIME_US     = 10;
   localparam int          LOCK_CYC         = LOCK_TIME_US * CLK_MHZ;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_BITS   = 2'b01,
      ST_ACK    = 2'b11,
      ST_IGNORE = 2'b10
   } serial_state_t;

   typedef struct packed {
      logic       valid;
      logic       idx;
      logic [7:0] data;
   } reg_write_t;

   typedef struct packed {
      logic bypass;
      logic low_power;
      logic pll_run;
   } pll_mode_t;
endpackage

// ### sync2.sv
// two-flop level synchroniser, one bit per lane
// assumes each lane is an independent slow level
`timescale 1ns/1ps
module sync2 #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clock_i,
   input  wire logic         arst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_r <= RST_VAL;
         q_r    <= RST_VAL;
      end else begin
         meta_r <= d_i;
         q_r    <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule

// ### freq_detect.sv
// low input frequency detector: ref clock divided, edges counted per window
// assumes ref_clk_i may stop entirely; the result lives on clock_i
`timescale 1ns/1ps
module freq_detect
   import clkbuf_pkg::*;
#(
   parameter int DET_FREQ_MHZ = DET_FREQ_DEF_MHZ
) (
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   input  wire logic ref_clk_i,
   output logic      low_freq_o
);
   localparam int         THRESH_I = 2 * DET_FREQ_MHZ * DET_WINDOW_NS / 1000 / (2 ** DIV_BITS);
   localparam logic [7:0] THRESH   = 8'(THRESH_I);
   localparam logic [7:0] WIN_LAST = 8'(DET_WINDOW_CYC - 1);

   logic [DIV_BITS-1:0] div_r;
   logic                div_s;
   logic                div_q_r;
   logic [7:0]          edge_cnt_r;
   logic [7:0]          edge_cnt_nxt;
   logic [7:0]          win_cnt_r;
   logic [7:0]          win_cnt_nxt;
   logic                low_r;
   logic                low_nxt;

   // divide first so that even 140 MHz is slow enough to sample here
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   sync2 #(.W(1), .RST_VAL(1'b0)) u_div_sync (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .d_i      (div_r[DIV_BITS-1]),
      .q_o      (div_s)
   );

   always_comb begin
      win_cnt_nxt  = win_cnt_r + 1'b1;
      edge_cnt_nxt = edge_cnt_r + 8'(div_s ^ div_q_r);
      low_nxt      = low_r;
      if (win_cnt_r == WIN_LAST) begin
         low_nxt      = edge_cnt_nxt < THRESH;
         win_cnt_nxt  = '0;
         edge_cnt_nxt = '0;
      end
   end

   // starts low-frequency: no outputs until a clock has been seen
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q_r    <= 1'b0;
         edge_cnt_r <= '0;
         win_cnt_r  <= '0;
         low_r      <= 1'b1;
      end else begin
         div_q_r    <= div_s;
         edge_cnt_r <= edge_cnt_nxt;
         win_cnt_r  <= win_cnt_nxt;
         low_r      <= low_nxt;
      end
   end

   assign low_freq_o = low_r;
endmodule

// ### serial_host_model.sv
// two-wire bus master standing in for the memory system host
// assumes the bench resolves the open-drain data wire; bus shortened to 80 clocks a bit
`timescale 1ns/1ps
module serial_host_model #(
   parameter int HALF = 40
) (
   input  wire logic clock_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic half_bit();
      repeat (HALF) @(negedge clock_i);
   endtask

   // master only: the slave never starts a transfer
   task automatic start_cond();
      sda_low_o = 1'b0;
      scl_o     = 1'b1;
      half_bit();
      sda_low_o = 1'b1;
      half_bit();
      scl_o = 1'b0;
   endtask

   task automatic stop_cond();
      sda_low_o = 1'b1;
      half_bit();
      scl_o = 1'b1;
      half_bit();
      sda_low_o = 1'b0;
      half_bit();
   endtask

   // msb first, data only changes with the clock low
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low_o = ~b[i];
         half_bit();
         scl_o = 1'b1;
         half_bit();
         scl_o = 1'b0;
      end
      // released line floats to the pull-up level, never the last bit
      sda_low_o = 1'b0;
      half_bit();
      scl_o = 1'b1;
      repeat (HALF / 2) @(negedge clock_i);
      ack = (sda_i === 1'b0);
      repeat (HALF / 2) @(negedge clock_i);
      scl_o = 1'b0;
   endtask
endmodule

// ### tb.sv
// self-checking bench for the clock buffer output control
// assumes the design asserts its own timing rules internally
`timescale 1ns/1ps
module tb;
   import clkbuf_pkg::*;

   logic                 clock_i;
   logic                 arst_n_i;
   logic                 ref_clk_i;
   logic                 ref_en;
   logic                 analog_supply_pin_i;
   logic                 scl;
   logic                 host_low;
   wire logic            sda_wire;
   logic                 sda_o;
   logic                 sda_oe;
   logic [NUM_PAIRS-1:0] pair_oe_o;
   logic                 fb_oe_o;
   logic                 pll_run_o;
   logic                 bypass_o;
   logic                 low_power_o;
   logic                 lock_wait_o;
   int                   fail_count;
   int                   cmp_count;

   // open drain with pull-up: any party pulling low wins
   assign sda_wire = (host_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

   clock_buffer_output_control #(.DET_FREQ_MHZ(4)) clock_buffer_output_control_inst (
      .clock_i               (clock_i),
      .arst_n_i              (arst_n_i),
      .ref_clk_i             (ref_clk_i),
      .scl_i                 (scl),
      .serial_data_line_i    (sda_wire),
      .analog_supply_pin_i   (analog_supply_pin_i),
      .serial_data_line_o    (sda_o),
      .serial_data_line_oe_o (sda_oe),
      .pair_oe_o             (pair_oe_o),
      .fb_oe_o               (fb_oe_o),
      .pll_run_o             (pll_run_o),
      .bypass_o              (bypass_o),
      .low_power_o           (low_power_o),
      .lock_wait_o           (lock_wait_o)
   );

   serial_host_model serial_host_model_inst (
      .clock_i   (clock_i),
      .sda_i     (sda_wire),
      .scl_o     (scl),
      .sda_low_o (host_low)
   );

   ////////////////////////////////////////////////////////////////////////////////
   initial clock_i = 1'b0;
   always #12.5 clock_i = ~clock_i;

   // 8 MHz reference, odd phase; stands low while stopped
   initial begin
      ref_clk_i = 1'b0;
      #7;
      forever begin
         #62.5;
         ref_clk_i = ref_en ? ~ref_clk_i : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic test_done();
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [9:0] exp_pairs(input logic [7:0] d0, input logic [7:0] d1);
      logic [9:0] e;
      for (int i = 0; i < 8; i++) e[i] = d0[7-i];
      e[8] = d1[7];
      e[9] = d1[6];
      return e;
   endfunction

   // bytes left-aligned in a 64-bit word, ack expected per byte
   task automatic write_frame(input logic [63:0] bytes, input int n, input logic ack_exp);
      logic ack;
      serial_host_model_inst.start_cond();
      for (int i = 0; i < n; i++) begin
         serial_host_model_inst.send_byte(bytes[63-8*i -: 8], ack);
         chk("ack", {31'h0, ack_exp}, {31'h0, ack});
      end
      serial_host_model_inst.stop_cond();
      repeat (40) @(negedge clock_i);
   endtask

   task automatic lock_check();
      int n;
      for (n = 0; n < 2000 && pll_run_o !== 1'b1; n++) @(negedge clock_i);
      chk("pll_run", 32'h1, {31'h0, pll_run_o});
      for (n = 0; n < 2000 && lock_wait_o === 1'b1; n++) @(negedge clock_i);
      chk("lock_cycles", LOCK_CYC, n);
   endtask

   // enables change only while the output clock is low
   always @(pair_oe_o) begin
      if (arst_n_i === 1'b1) begin
         chk("ref_at_change", 32'h0, {31'h0, ref_clk_i});
      end
   end

   initial begin
      #1500000;
      fail_count++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      fail_count          = 0;
      cmp_count           = 0;
      arst_n_i            = 1'b0;
      ref_en              = 1'b1;
      analog_supply_pin_i = 1'b1;
      repeat (16) @(negedge clock_i);
      chk("rst_low_power", 32'h1, {31'h0, low_power_o});
      chk("rst_pairs", 32'h0, {22'h0, pair_oe_o});
      arst_n_i = 1'b1;
      lock_check();
      repeat (40) @(negedge clock_i);
      chk("pairs_default", 32'h3FF, {22'h0, pair_oe_o});
      chk("fb_default", 32'h1, {31'h0, fb_oe_o});
      chk("low_power", 32'h0, {31'h0, low_power_o});
      write_frame({8'hD2, 8'h00, 8'h00, 8'h5A, 8'h40, 24'h0}, 5, 1'b1);
      chk("pairs_a", {22'h0, exp_pairs(8'h5A, 8'h40)}, {22'h0, pair_oe_o});
      chk("fb_kept", 32'h1, {31'h0, fb_oe_o});
      chk("no_relock", 32'h0, {31'h0, lock_wait_o});
      // reserved bits set and trailing bytes must be dropped
      write_frame({8'hD2, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h0}, 7, 1'b1);
      chk("pairs_b", 32'h3FF, {22'h0, pair_oe_o});
      write_frame({8'hD3, 56'h0}, 1, 1'b0);
      write_frame({8'hD4, 56'h0}, 1, 1'b0);
      chk("pairs_nack", 32'h3FF, {22'h0, pair_oe_o});
      write_frame({8'hD2, 8'h00, 8'h00, 8'h00, 32'h0}, 4, 1'b1);
      chk("pairs_partial", {22'h0, exp_pairs(8'h00, 8'hC0)}, {22'h0, pair_oe_o});
      chk("sda_out", 32'h0, {31'h0, sda_o});
      write_frame({8'hD2, 8'h00, 8'h00, 8'hFF, 8'hC0, 24'h0}, 5, 1'b1);
      chk("pairs_back", 32'h3FF, {22'h0, pair_oe_o});
      analog_supply_pin_i = 1'b0;
      repeat (20) @(negedge clock_i);
      chk("bypass", 32'h1, {31'h0, bypass_o});
      chk("bypass_pll", 32'h0, {31'h0, pll_run_o});
      chk("bypass_pairs", 32'h3FF, {22'h0, pair_oe_o});
      chk("bypass_fb", 32'h1, {31'h0, fb_oe_o});
      analog_supply_pin_i = 1'b1;
      lock_check();
      ref_en = 1'b0;
      for (int n = 0; n < 1000 && low_power_o !== 1'b1; n++) @(negedge clock_i);
      chk("slow_low_power", 32'h1, {31'h0, low_power_o});
      chk("slow_pll", 32'h0, {31'h0, pll_run_o});
      chk("slow_lock", 32'h1, {31'h0, lock_wait_o});
      ref_en = 1'b1;
      lock_check();
      repeat (40) @(negedge clock_i);
      chk("pairs_resume", 32'h3FF, {22'h0, pair_oe_o});
      test_done();
   end
endmodule
